// File: swrcc_pkg.sv
// constants for the wait step, reset release and converter settings
// assumes a 40 MHz mclk; all users refer to names as swrcc_pkg::name
package swrcc_pkg;

    // ----------------
    // register offsets
    // ----------------
    localparam logic [7:0] ADDR_WAIT_CTRL  = 8'h97;
    localparam logic [7:0] ADDR_RST_TIMING = 8'h99;
    localparam logic [7:0] ADDR_CONV2_ILIM = 8'h9A;
    localparam logic [7:0] ADDR_CONV3_ILIM = 8'h9B;
    localparam logic [7:0] ADDR_CONV1_ILIM = 8'h9C;
    localparam logic [7:0] ADDR_CONV1_CFG  = 8'h9E;
    localparam logic [7:0] ADDR_CONV3_CFG  = 8'h9F;
    localparam logic [7:0] ADDR_CONV2_CFG  = 8'hA0;
    localparam logic [7:0] REG_RESET_VAL   = 8'h00;

    // ----------------
    // field positions
    // ----------------
    localparam int WAIT_DIR_LSB   = 6;
    localparam int TIMEOUT_BIT    = 5;
    localparam int WAIT_SRC_BIT   = 4;
    localparam int WAIT_TIME_LSB  = 0;
    localparam int RST_EVENT_LSB  = 6;
    localparam int RST_DELAY_LSB  = 0;
    localparam int ILIM_LSB       = 0;
    localparam int MODE_LSB       = 6;
    localparam int PD_OFF_BIT     = 5;

    // ----------------
    // encodings
    // ----------------
    typedef enum logic [1:0] {
        MODE_SETTING = 2'b00,
        MODE_PFM     = 2'b01,
        MODE_SYNC    = 2'b10,
        MODE_AUTO    = 2'b11
    } swrcc_mode_type;

    localparam logic [1:0] EVT_EXTERNAL_WAKEUP_EVENT = 2'b00;
    localparam logic [1:0] EVT_SYSTEM_UP_EVENT     = 2'b01;
    localparam logic [1:0] EVT_POWER_UP_EVENT     = 2'b10;
    localparam logic [1:0] EVT_RESET_EXIT = 2'b11;

    // ----------------
    // timing
    // ----------------
    localparam int CLK_FREQ_MHZ    = 40;
    localparam int TICK_TIME_US    = 512;
    localparam int TICK_CYCLES     = TICK_TIME_US * CLK_FREQ_MHZ;
    localparam int TIMEOUT_TIME_MS = 500;
    localparam int TIMEOUT_TICKS   = (TIMEOUT_TIME_MS * 1000) / TICK_TIME_US;
    localparam int RST_UNIT_US     = 1024;
    localparam int RST_UNIT_TICKS  = RST_UNIT_US / TICK_TIME_US;

    // ----------------
    // current limits in mA
    // ----------------
    localparam int LIM_HI_BASE_MA = 1700;
    localparam int LIM_LO_BASE_MA = 700;
    localparam int LIM_STEP_MA    = 100;

endpackage

// File: swrcc_tick_if.sv
// tick handshake between the control block and its prescalers
// assumes both ends share mclk
`timescale 1ns/10ps
`default_nettype none

interface swrcc_tick_if;
    logic restart;
    logic tick;
    modport timer (input restart, output tick);
    modport user  (output restart, input tick);
endinterface

`default_nettype wire

// File: swrcc_tick_gen.sv
// prescaler giving one tick per TICK_CYCLES mclk cycles
// assumes restart is a one-cycle pulse from logic on mclk
`timescale 1ns/10ps
`default_nettype none

module swrcc_tick_gen #(
    parameter int TICK_CYCLES = swrcc_pkg::TICK_CYCLES
) (
    input  wire logic     mclk,
    input  wire logic     rst_b,
    swrcc_tick_if.timer   tk
);
    localparam int CW = $clog2(TICK_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

    logic [CW-1:0] cnt_q;
    logic          tick_q;

    // restart realigns phase so the first tick is a full period away
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else if (tk.restart) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else if (cnt_q == LAST) begin
            cnt_q  <= '0;
            tick_q <= 1'b1;
        end else begin
            cnt_q  <= cnt_q + 1'b1;
            tick_q <= 1'b0;
        end
    end

    assign tk.tick = tick_q;

endmodule

`default_nettype wire

// File: swrcc_ctrl.sv
// wait step control, timed reset release and converter settings
// assumes sequencer strobes and events are one-cycle pulses on mclk;
// external_wait_input is an asynchronous pin
//
// Behaviour
// - wait direction 00 none, 01 up only, 10 down only, 11 both.
// - wait source 0 holds for external input, 1 holds for timer.
// - timeout bit 1 abandons the external wait after 500 ms.
// - wait time 0000 adds no delay beyond the slot.
// - wait time codes give 512 us doubling per code up to 4.2 s at code 14; code 15 never ends.
// - reset event picks wakeup, system-up, power-up or reset exit.
// - reset delay zero releases system reset at once after event.
// - delay 1-31 is n*1.024 ms, 32-63 is 32.768 ms*(n-31).
// - converter2 limit is 1700 mA plus 100 mA per code.
// - converter3 limit is 700 mA plus 100 mA per code.
// - converter1 limit is 700+100*code mA, doubled in full current.
// - converter1 mode 00 sleep bits, 01 pfm, 10 sync, 11 auto.
// - converters 2 and 3 share encoding; conv2 uses conv3 bits.
// - pull-down off bit keeps pull-down off while disabled.
// - sleep bit applies in mode 00: 0 sync, 1 pfm.
// - waiting happens only at the programmed wait step slot.
`timescale 1ns/10ps
`default_nettype none

module swrcc_ctrl #(
    parameter int TICK_CYCLES = swrcc_pkg::TICK_CYCLES
) (
    input  wire logic                 mclk,
    input  wire logic                 rst_b,
    // register port
    input  wire logic                 reg_wr_en,
    input  wire logic                 reg_rd_en,
    input  wire logic [7:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    output logic      [7:0]           reg_rdata,
    // sequencer
    input  wire logic [3:0]           wait_step_slot,
    input  wire logic [3:0]           seq_slot,
    input  wire logic                 seq_slot_enter,
    input  wire logic                 seq_going_up,
    output logic                      seq_wait_hold,
    input  wire logic                 external_wait_input,
    // reset release
    input  wire logic                 external_wakeup_event,
    input  wire logic                 system_up_event,
    input  wire logic                 power_up_event,
    input  wire logic                 reset_mode_exit_event,
    output logic                      system_reset_out_n,
    // converter inputs
    input  wire logic                 conv1_full_current,
    input  wire logic                 conv1_setting_a_sleep,
    input  wire logic                 conv1_setting_b_sleep,
    input  wire logic                 conv1_setting_b_active,
    input  wire logic                 conv3_setting_a_sleep,
    input  wire logic                 conv3_setting_b_sleep,
    input  wire logic                 conv3_setting_b_active,
    input  wire logic                 conv2_setting_b_active,
    input  wire logic [2:0]           conv_enabled,
    // converter outputs
    output logic      [12:0]          conv1_limit_ma,
    output logic      [12:0]          conv2_limit_ma,
    output logic      [12:0]          conv3_limit_ma,
    output swrcc_pkg::swrcc_mode_type conv1_mode_eff,
    output swrcc_pkg::swrcc_mode_type conv2_mode_eff,
    output swrcc_pkg::swrcc_mode_type conv3_mode_eff,
    output logic      [2:0]           conv_pulldown_on
);

    // ----------------
    // helpers
    // ----------------
    function automatic logic [12:0] limit_ma(input int base,
                                             input logic [3:0] code);
        limit_ma = 13'(base + int'(code) * swrcc_pkg::LIM_STEP_MA);
    endfunction

    // mode 00 follows the sleep bit of whichever setting is active
    function automatic swrcc_pkg::swrcc_mode_type resolve(
        input logic [1:0] mode,
        input logic       sl_a,
        input logic       sl_b,
        input logic       b_act);
        logic sl;
        sl = b_act ? sl_b : sl_a;
        if (mode == swrcc_pkg::MODE_SETTING) begin
            resolve = sl ? swrcc_pkg::MODE_PFM : swrcc_pkg::MODE_SYNC;
        end else begin
            resolve = swrcc_pkg::swrcc_mode_type'(mode);
        end
    endfunction

    // ----------------
    // registers
    // ----------------
    logic [7:0] wait_ctrl_q;
    logic [7:0] rst_timing_q;
    logic [3:0] conv1_limit_code;
    logic [3:0] conv2_limit_code;
    logic [3:0] conv3_limit_code;
    logic [7:0] conv1_cfg_q;
    logic [7:0] conv2_cfg_q;
    logic [7:0] conv3_cfg_q;
    logic [7:0] rdata_q;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wait_ctrl_q      <= swrcc_pkg::REG_RESET_VAL;
            rst_timing_q     <= swrcc_pkg::REG_RESET_VAL;
            conv1_limit_code <= 4'h0;
            conv2_limit_code <= 4'h0;
            conv3_limit_code <= 4'h0;
            conv1_cfg_q      <= swrcc_pkg::REG_RESET_VAL;
            conv2_cfg_q      <= swrcc_pkg::REG_RESET_VAL;
            conv3_cfg_q      <= swrcc_pkg::REG_RESET_VAL;
        end else if (reg_wr_en) begin
            case (reg_addr)
                swrcc_pkg::ADDR_WAIT_CTRL:  wait_ctrl_q  <= reg_wdata;
                swrcc_pkg::ADDR_RST_TIMING: rst_timing_q <= reg_wdata;
                swrcc_pkg::ADDR_CONV2_ILIM: conv2_limit_code <=
                    reg_wdata[swrcc_pkg::ILIM_LSB +: 4];
                swrcc_pkg::ADDR_CONV3_ILIM: conv3_limit_code <=
                    reg_wdata[swrcc_pkg::ILIM_LSB +: 4];
                swrcc_pkg::ADDR_CONV1_ILIM: conv1_limit_code <=
                    reg_wdata[swrcc_pkg::ILIM_LSB +: 4];
                swrcc_pkg::ADDR_CONV1_CFG:  conv1_cfg_q  <= reg_wdata;
                swrcc_pkg::ADDR_CONV3_CFG:  conv3_cfg_q  <= reg_wdata;
                swrcc_pkg::ADDR_CONV2_CFG:  conv2_cfg_q  <= reg_wdata;
                default: ;
            endcase
        end
    end

    // upper nibble of the limit registers reads zero
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= 8'h00;
        end else if (reg_rd_en) begin
            case (reg_addr)
                swrcc_pkg::ADDR_WAIT_CTRL:  rdata_q <= wait_ctrl_q;
                swrcc_pkg::ADDR_RST_TIMING: rdata_q <= rst_timing_q;
                swrcc_pkg::ADDR_CONV2_ILIM: rdata_q <= {4'h0, conv2_limit_code};
                swrcc_pkg::ADDR_CONV3_ILIM: rdata_q <= {4'h0, conv3_limit_code};
                swrcc_pkg::ADDR_CONV1_ILIM: rdata_q <= {4'h0, conv1_limit_code};
                swrcc_pkg::ADDR_CONV1_CFG:  rdata_q <= conv1_cfg_q;
                swrcc_pkg::ADDR_CONV3_CFG:  rdata_q <= conv3_cfg_q;
                swrcc_pkg::ADDR_CONV2_CFG:  rdata_q <= conv2_cfg_q;
                default:                    rdata_q <= 8'h00;
            endcase
        end
    end

    assign reg_rdata = rdata_q;

    // ----------------
    // field views
    // ----------------
    logic [1:0] wait_dir;
    logic       timeout_en;
    logic       wait_on_timer;
    logic [3:0] wait_time;
    logic [1:0] rst_event_sel;
    logic [5:0] rst_delay;

    assign wait_dir      = wait_ctrl_q[swrcc_pkg::WAIT_DIR_LSB +: 2];
    assign timeout_en    = wait_ctrl_q[swrcc_pkg::TIMEOUT_BIT];
    assign wait_on_timer = wait_ctrl_q[swrcc_pkg::WAIT_SRC_BIT];
    assign wait_time     = wait_ctrl_q[swrcc_pkg::WAIT_TIME_LSB +: 4];
    assign rst_event_sel = rst_timing_q[swrcc_pkg::RST_EVENT_LSB +: 2];
    assign rst_delay     = rst_timing_q[swrcc_pkg::RST_DELAY_LSB +: 6];

    // ----------------
    // external wait input synchroniser
    // ----------------
    logic ext_wait_s1_q;
    logic ext_wait_s2_q;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ext_wait_s1_q <= 1'b0;
            ext_wait_s2_q <= 1'b0;
        end else begin
            ext_wait_s1_q <= external_wait_input;
            ext_wait_s2_q <= ext_wait_s1_q;
        end
    end

    // ----------------
    // wait step state machine
    // ----------------
    typedef enum logic [1:0] {
        W_IDLE = 2'b00,
        W_EXT  = 2'b01,
        W_TMR  = 2'b10
    } swrcc_wait_type;

    swrcc_wait_type wstate_q;
    swrcc_wait_type wstate_d;
    logic [13:0]    wcnt_q;
    logic [13:0]    wcnt_inc;
    logic [14:0]    wait_target;
    logic           dir_match;
    logic           wait_start;
    logic           hold_q;

    swrcc_tick_if wtk ();

    swrcc_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_wait_tick (
        .mclk  (mclk),
        .rst_b (rst_b),
        .tk    (wtk.timer)
    );

    // code n counts 2^(n-1) ticks of 512 us
    assign wait_target = 15'h0001 << (wait_time - 4'h1);
    assign wcnt_inc    = wcnt_q + 14'h0001;
    // bit 0 enables up, bit 1 enables down
    assign dir_match   = seq_going_up ? wait_dir[0] : wait_dir[1];
    // a new slot entry while holding is ignored, not a restart
    assign wait_start  = seq_slot_enter && dir_match && wstate_q == W_IDLE
                       && (seq_slot == wait_step_slot);
    assign wtk.restart = wait_start;

    always_comb begin
        wstate_d = wstate_q;
        case (wstate_q)
            W_IDLE: begin
                if (wait_start) begin
                    if (!wait_on_timer) begin
                        wstate_d = W_EXT;
                    end else if (wait_time != 4'h0) begin
                        wstate_d = W_TMR;
                    end
                end
            end
            W_EXT: begin
                if (ext_wait_s2_q) begin
                    wstate_d = W_IDLE;
                end else if (timeout_en && wtk.tick
                             && int'(wcnt_inc) >=
                                swrcc_pkg::TIMEOUT_TICKS) begin
                    wstate_d = W_IDLE;
                end
            end
            W_TMR: begin
                if (wtk.tick && {1'b0, wcnt_inc} >= wait_target) begin
                    wstate_d = W_IDLE;
                end
            end
            default: wstate_d = W_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wstate_q <= W_IDLE;
            hold_q   <= 1'b0;
        end else begin
            wstate_q <= wstate_d;
            hold_q   <= (wstate_d != W_IDLE);
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wcnt_q <= '0;
        end else if (wait_start) begin
            wcnt_q <= '0;
        end else if (wstate_q != W_IDLE && wtk.tick) begin
            wcnt_q <= wcnt_inc;
        end
    end

    assign seq_wait_hold = hold_q;

    // ----------------
    // reset release timer
    // ----------------
    logic        rst_hit;
    logic        rst_run_q;
    logic        rst_out_q;
    logic [11:0] rcnt_q;
    logic [11:0] rcnt_inc;
    logic [11:0] rst_target;

    swrcc_tick_if rtk ();

    swrcc_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_rst_tick (
        .mclk  (mclk),
        .rst_b (rst_b),
        .tk    (rtk.timer)
    );

    always_comb begin
        case (rst_event_sel)
            swrcc_pkg::EVT_EXTERNAL_WAKEUP_EVENT: rst_hit = external_wakeup_event;
            swrcc_pkg::EVT_SYSTEM_UP_EVENT:     rst_hit = system_up_event;
            swrcc_pkg::EVT_POWER_UP_EVENT:     rst_hit = power_up_event;
            default:                   rst_hit = reset_mode_exit_event;
        endcase
    end

    // counted in 512 us ticks, two per 1.024 ms unit
    always_comb begin
        if (rst_delay < 6'd32) begin
            rst_target = 12'(int'(rst_delay)
                       * swrcc_pkg::RST_UNIT_TICKS);
        end else begin
            rst_target = 12'((int'(rst_delay) - 31) * 32
                       * swrcc_pkg::RST_UNIT_TICKS);
        end
    end

    assign rcnt_inc    = rcnt_q + 12'h001;
    assign rtk.restart = rst_hit;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_out_q <= 1'b0;
            rst_run_q <= 1'b0;
            rcnt_q    <= '0;
        end else if (rst_hit) begin
            rcnt_q <= '0;
            if (rst_delay == 6'd0) begin
                rst_out_q <= 1'b1;
                rst_run_q <= 1'b0;
            end else begin
                rst_out_q <= 1'b0;
                rst_run_q <= 1'b1;
            end
        end else if (rst_run_q && rtk.tick) begin
            rcnt_q <= rcnt_inc;
            if (rcnt_inc >= rst_target) begin
                rst_out_q <= 1'b1;
                rst_run_q <= 1'b0;
            end
        end
    end

    assign system_reset_out_n = rst_out_q;

    // ----------------
    // converter settings
    // ----------------
    logic [12:0]               lim1_q;
    logic [12:0]               lim2_q;
    logic [12:0]               lim3_q;
    swrcc_pkg::swrcc_mode_type mode1_q;
    swrcc_pkg::swrcc_mode_type mode2_q;
    swrcc_pkg::swrcc_mode_type mode3_q;
    logic [2:0]                pd_q;
    logic [2:0]                pd_off;
    logic [12:0]               lim1_base;

    assign lim1_base = limit_ma(swrcc_pkg::LIM_LO_BASE_MA,
                                conv1_limit_code);
    assign pd_off = {conv3_cfg_q[swrcc_pkg::PD_OFF_BIT],
                     conv2_cfg_q[swrcc_pkg::PD_OFF_BIT],
                     conv1_cfg_q[swrcc_pkg::PD_OFF_BIT]};

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            lim1_q <= '0;
            lim2_q <= '0;
            lim3_q <= '0;
        end else begin
            lim1_q <= conv1_full_current ? {lim1_base[11:0], 1'b0}
                                         : lim1_base;
            lim2_q <= limit_ma(swrcc_pkg::LIM_HI_BASE_MA,
                               conv2_limit_code);
            lim3_q <= limit_ma(swrcc_pkg::LIM_LO_BASE_MA,
                               conv3_limit_code);
        end
    end

    // reset loads sync; from the next edge mode 00 follows the sleep bits
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            mode1_q <= swrcc_pkg::MODE_SYNC;
            mode2_q <= swrcc_pkg::MODE_SYNC;
            mode3_q <= swrcc_pkg::MODE_SYNC;
        end else begin
            mode1_q <= resolve(conv1_cfg_q[swrcc_pkg::MODE_LSB +: 2],
                               conv1_setting_a_sleep,
                               conv1_setting_b_sleep,
                               conv1_setting_b_active);
            // conv2 follows the conv3 sleep bits, as printed
            mode2_q <= resolve(conv2_cfg_q[swrcc_pkg::MODE_LSB +: 2],
                               conv3_setting_a_sleep,
                               conv3_setting_b_sleep,
                               conv2_setting_b_active);
            mode3_q <= resolve(conv3_cfg_q[swrcc_pkg::MODE_LSB +: 2],
                               conv3_setting_a_sleep,
                               conv3_setting_b_sleep,
                               conv3_setting_b_active);
        end
    end

    // pull-down only while disabled and not switched off
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pd_q <= 3'h7;
        end else begin
            pd_q <= ~conv_enabled & ~pd_off;
        end
    end

    assign conv1_limit_ma   = lim1_q;
    assign conv2_limit_ma   = lim2_q;
    assign conv3_limit_ma   = lim3_q;
    assign conv1_mode_eff   = mode1_q;
    assign conv2_mode_eff   = mode2_q;
    assign conv3_mode_eff   = mode3_q;
    assign conv_pulldown_on = pd_q;

endmodule

`default_nettype wire

// File: swrcc_ctrl_sva.sv
// checker for the wait step, reset release and converter outputs
// assumes it sees only the ports of swrcc_ctrl, attached by bind
`timescale 1ns/10ps
`default_nettype none
module swrcc_ctrl_sva #(
    parameter int TICK_CYCLES = swrcc_pkg::TICK_CYCLES
) (
    input wire logic        mclk,
    input wire logic        rst_b,
    input wire logic        reg_rd_en,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_rdata,
    input wire logic [3:0]  wait_step_slot,
    input wire logic [3:0]  seq_slot,
    input wire logic        seq_slot_enter,
    input wire logic        seq_wait_hold,
    input wire logic        external_wakeup_event,
    input wire logic        system_up_event,
    input wire logic        power_up_event,
    input wire logic        reset_mode_exit_event,
    input wire logic        system_reset_out_n,
    input wire logic [12:0] conv1_limit_ma,
    input wire logic [12:0] conv2_limit_ma,
    input wire logic [12:0] conv3_limit_ma,
    input wire logic [1:0]  conv1_mode_eff,
    input wire logic [1:0]  conv2_mode_eff,
    input wire logic [1:0]  conv3_mode_eff,
    input wire logic [2:0]  conv_enabled,
    input wire logic [2:0]  conv_pulldown_on
);
    wire logic any_evt = external_wakeup_event | system_up_event
                       | power_up_event | reset_mode_exit_event;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    lim2_range_a: assert property ($past(rst_b) |->
        conv2_limit_ma >= 13'd1700 && conv2_limit_ma <= 13'd3200)
        else $error("conv2 limit range");
    lim3_range_a: assert property ($past(rst_b) |->
        conv3_limit_ma >= 13'd700 && conv3_limit_ma <= 13'd2200)
        else $error("conv3 limit range");
    lim1_step_a: assert property ($past(rst_b) |->
        conv1_limit_ma >= 13'd700 && conv1_limit_ma % 13'd100 == 13'd0)
        else $error("conv1 limit step");
    mode_resolved_a: assert property ($past(rst_b) |->
        conv1_mode_eff != 2'b00 && conv2_mode_eff != 2'b00
        && conv3_mode_eff != 2'b00) else $error("mode left unresolved");
    pulldown_idle_a: assert property ($past(rst_b) |->
        (conv_pulldown_on & $past(conv_enabled)) == 3'h0)
        else $error("pull-down while enabled");
    hold_cause_a: assert property ($rose(seq_wait_hold) |->
        $past(seq_slot_enter) && $past(seq_slot) == $past(wait_step_slot))
        else $error("hold outside wait slot");
    reset_cause_a: assert property ($fell(system_reset_out_n) |->
        $past(any_evt)) else $error("reset without event");
    reset_stays_a: assert property (
        system_reset_out_n && !any_evt |=> system_reset_out_n)
        else $error("reset reasserted");
    limit_nibble_a: assert property (
        reg_rd_en && reg_addr == 8'h9A |=> reg_rdata[7:4] == 4'h0)
        else $error("limit upper bits set");
    cover property (seq_wait_hold [*3]);
    cover property ($rose(system_reset_out_n));
    cover property (conv1_limit_ma > 13'd2200);
endmodule
bind swrcc_ctrl swrcc_ctrl_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (.*);
`default_nettype wire

// File: swrcc_host.sv
// host processor model: single-byte register accesses on the strobe port
// assumes strobes are sampled on the rising edge of mclk
`timescale 1ns/10ps
`default_nettype none
module swrcc_host (
    input  wire logic       mclk,
    output logic            wr_en,
    output logic            rd_en,
    output logic      [7:0] addr,
    output logic      [7:0] wdata
);
    initial {wr_en, rd_en, addr, wdata} = 18'h0;
    // one strobe cycle; read data is settled when the task returns
    task automatic xfer(input logic w, input logic [7:0] a, d);
        @(posedge mclk) #1;
        {wr_en, rd_en, addr, wdata} = {w, !w, a, d};
        @(posedge mclk) #1;
        {wr_en, rd_en} = 2'b00;
    endtask
endmodule
`default_nettype wire

// File: tb_seq_wait_reset_converter_cfg.sv
// testbench for wait step, reset release and converter settings
// assumes swrcc_ctrl with a short tick and the host model on its port
`timescale 1ns/10ps
`default_nettype none
module tb_seq_wait_reset_converter_cfg;
    localparam int TK = 4;
    logic        mclk, rst_b, reg_wr_en, reg_rd_en, seq_slot_enter, w;
    logic        seq_going_up, seq_wait_hold, external_wait_input;
    logic        system_reset_out_n, conv1_full_current;
    logic        conv1_setting_a_sleep, conv1_setting_b_sleep;
    logic        conv1_setting_b_active, conv3_setting_a_sleep;
    logic        conv3_setting_b_sleep, conv3_setting_b_active;
    logic        conv2_setting_b_active;
    wire logic   external_wakeup_event, system_up_event;
    wire logic   power_up_event, reset_mode_exit_event;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata;
    logic [3:0]  wait_step_slot, seq_slot, evt;
    logic [2:0]  conv_enabled, conv_pulldown_on;
    logic [12:0] conv1_limit_ma, conv2_limit_ma, conv3_limit_ma;
    swrcc_pkg::swrcc_mode_type conv1_mode_eff, conv2_mode_eff;
    swrcc_pkg::swrcc_mode_type conv3_mode_eff;
    logic [7:0]  ad [8] = '{8'h97, 8'h99, 8'h9A, 8'h9B, 8'h9C, 8'h9E,
                           8'h9F, 8'hA0};
    logic [5:0]  dly [4] = '{6'd0, 6'd1, 6'd31, 6'd33};
    int          tks [4] = '{0, 2, 62, 128};
    int          failures, samples_checked, n;
    assign {reset_mode_exit_event, power_up_event, system_up_event,
            external_wakeup_event} = evt;
    swrcc_ctrl #(.TICK_CYCLES(TK)) dut (.*);
    swrcc_host h (.mclk(mclk), .wr_en(reg_wr_en), .rd_en(reg_rd_en),
                  .addr(reg_addr), .wdata(reg_wdata));
    task automatic chk(input logic [12:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        if (failures == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // pulses events and slot entry, returns one edge after they are taken
    task automatic fire(input logic [3:0] e, input logic s);
        @(posedge mclk) #1;
        {evt, seq_slot_enter} = {e, s};
        @(posedge mclk) #1;
        {evt, seq_slot_enter} = 5'h0;
        @(posedge mclk) #1;
    endtask
    // counts edges until hold drops (r=0) or reset output releases (r=1)
    task automatic until_ok(input logic r, output int k);
        k = 0;
        while ((r ? !system_reset_out_n : seq_wait_hold) && k < 9000) begin
            @(posedge mclk) #1;
            k++;
        end
        if (k >= 9000) begin
            failures++;
            complete_run();
        end
    endtask
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    initial begin
        {rst_b, evt, seq_slot_enter, seq_going_up} = 7'h0;
        {external_wait_input, conv1_full_current, conv_enabled} = 5'h0;
        {wait_step_slot, seq_slot} = 8'h55;
        {conv1_setting_a_sleep, conv1_setting_b_sleep, conv1_setting_b_active,
         conv3_setting_a_sleep, conv3_setting_b_sleep, conv3_setting_b_active,
         conv2_setting_b_active} = 7'b1001010;
        repeat (4) @(posedge mclk);
        #1 rst_b = 1'b1;
        for (int i = 0; i < 8; i++) begin
            h.xfer(1'b0, ad[i], 8'h00);
            chk(reg_rdata, 8'h00);
            h.xfer(1'b1, ad[i], 8'hA5);
            h.xfer(1'b0, ad[i], 8'h00);
            chk(reg_rdata, (i inside {[2:4]}) ? 8'h05 : 8'hA5);
        end
        chk(conv2_limit_ma, 13'd2200);
        chk(conv3_limit_ma, 13'd1200);
        chk(conv_pulldown_on, 3'h0);
        conv1_full_current = 1'b1;
        @(posedge mclk) #1;
        chk(conv1_limit_ma, 13'd2400);
        for (int m = 0; m < 4; m++) begin
            for (int i = 5; i < 8; i++) h.xfer(1'b1, ad[i], 8'(m << 6));
            @(posedge mclk) #1;
            chk(conv1_mode_eff, 13'(m ? m : 1));
            chk(conv2_mode_eff, 13'(m ? m : 1));
            chk(conv3_mode_eff, 13'(m ? m : 2));
        end
        conv_enabled = 3'b101;
        @(posedge mclk) #1;
        chk(conv_pulldown_on, 3'b010);
        for (int e = 0; e < 4; e++) begin
            h.xfer(1'b1, 8'h99, {2'(e), dly[e]});
            fire(4'(1 << e), 1'b0);
            chk(system_reset_out_n, e == 0);
            until_ok(1'b1, n);
            chk(13'(n), 13'(tks[e] * TK));
            fire(~4'(1 << e), 1'b0);
            chk(system_reset_out_n, 1'b1);
        end
        for (int d = 0; d < 4; d++) begin
            h.xfer(1'b1, 8'h97, {2'(d), 6'h14});
            for (int u = 0; u < 2; u++) begin
                seq_going_up = u[0];
                w = u ? d[0] : d[1];
                fire(4'h0, 1'b1);
                chk(seq_wait_hold, w);
                until_ok(1'b0, n);
                if (w) chk(13'((n + 1) / TK), 13'd8);
            end
        end
        h.xfer(1'b1, 8'h97, 8'hD0);
        fire(4'h0, 1'b1);
        chk(seq_wait_hold, 1'b0);
        h.xfer(1'b1, 8'h97, 8'hC0);
        seq_slot = 4'h6;
        fire(4'h0, 1'b1);
        chk(seq_wait_hold, 1'b0);
        seq_slot = 4'h5;
        fire(4'h0, 1'b1);
        chk(seq_wait_hold, 1'b1);
        repeat (5) @(posedge mclk);
        #1 external_wait_input = 1'b1;
        until_ok(1'b0, n);
        chk(13'(n), 13'd3);
        external_wait_input = 1'b0;
        h.xfer(1'b1, 8'h97, 8'hE0);
        fire(4'h0, 1'b1);
        until_ok(1'b0, n);
        chk(13'((n + 1) / TK), 13'(swrcc_pkg::TIMEOUT_TICKS));
        complete_run();
    end
endmodule
`default_nettype wire
